// [vls_pkg.sv]
// command set constants, types and reset values of the voltage limit block
// assumes a decoded command port from an outside serial engine
// Operation
// - input overvoltage fault word, code 55, ADC detected
// - input undervoltage warning word, code 58
// - start conversion threshold at code 35
// - stop conversion threshold at code 36
// - input thresholds use signed exponent mantissa format
// - read-only output format byte returns linear, exponent
// - per-channel nominal set point, unsigned mantissa
// - all commanded outputs clamped to per-channel ceiling
// - output overvoltage fault above per-channel threshold
// - busy bits low while recalculating fault threshold
// - pull-down reaction: gates forced, no fault pin
// - overvoltage warning sets status bits and alert
// - overvoltage warning evaluated from ADC readings
// - margin high moves output to upper margin
// - margin low moves output to lower margin
// - set-point writes deferred during rise or fall
// - steady output ramps at programmed slew rate
// - per-channel output undervoltage warning threshold
// - per-channel output undervoltage fault threshold
// - read-only absolute ceiling word returns fixed value
package vls_pkg;
  // command codes
  localparam logic [7:0] VLS_FMT_CODE = 8'h20;
  localparam logic [7:0] VLS_NOM_CODE = 8'h21;
  localparam logic [7:0] VLS_CEIL_CODE = 8'h24;
  localparam logic [7:0] VLS_MHI_CODE = 8'h25;
  localparam logic [7:0] VLS_MLO_CODE = 8'h26;
  localparam logic [7:0] VLS_VON_CODE = 8'h35;
  localparam logic [7:0] VLS_VOFF_CODE = 8'h36;
  localparam logic [7:0] VLS_OVF_CODE = 8'h40;
  localparam logic [7:0] VLS_OVW_CODE = 8'h42;
  localparam logic [7:0] VLS_UVW_CODE = 8'h43;
  localparam logic [7:0] VLS_UVF_CODE = 8'h44;
  localparam logic [7:0] VLS_VIN_OVF_CODE = 8'h55;
  localparam logic [7:0] VLS_VIN_UVW_CODE = 8'h58;
  localparam logic [7:0] VLS_ABS_CODE = 8'hA5;
  // reset values
  localparam logic [7:0] VLS_FMT_VAL = 8'h14;
  localparam logic [15:0] VLS_NOM_RST = 16'h1000;
  localparam logic [15:0] VLS_CEIL_RST = 16'h599A;
  localparam logic [15:0] VLS_MHI_RST = 16'h10CD;
  localparam logic [15:0] VLS_MLO_RST = 16'h0F33;
  localparam logic [15:0] VLS_VON_RST = 16'hCAC0;
  localparam logic [15:0] VLS_VOFF_RST = 16'hCAA0;
  localparam logic [15:0] VLS_OVF_RST = 16'h119A;
  localparam logic [15:0] VLS_OVW_RST = 16'h1133;
  localparam logic [15:0] VLS_UVW_RST = 16'h0ECD;
  localparam logic [15:0] VLS_UVF_RST = 16'h0E66;
  localparam logic [15:0] VLS_VIN_OVF_RST = 16'hDB60;
  localparam logic [15:0] VLS_VIN_UVW_RST = 16'hCAA6;
  localparam logic [15:0] VLS_ABS_VAL = 16'h5B34;
  // signed exponent mantissa field layout
  localparam int VLS_EXP_HI = 15;
  localparam int VLS_EXP_LO = 11;
  localparam int VLS_MAN_W = 11;
  localparam logic [4:0] VLS_EXP_BIAS = 5'h10;
  localparam int VLS_FIX_W = 48;
  // common vendor status: bit 5 channel 0 busy, bit 6 channel 1 busy
  localparam int VLS_BUSY_BIT0 = 5;
  localparam logic [7:0] VLS_COMMON_IDLE = 8'hFF;
  // timing
  localparam int VLS_CLK_MHZ = 250;
  localparam int VLS_RECALC_TIME_US = 10000;
  localparam int VLS_RECALC_CYC = VLS_RECALC_TIME_US * VLS_CLK_MHZ;
  localparam int VLS_BUSY_W = 22;
  localparam int VLS_SLEW_TICK_NS = 1000;
  localparam int VLS_SLEW_TICK_CYC = (VLS_SLEW_TICK_NS * VLS_CLK_MHZ) / 1000;
  localparam int VLS_TICK_W = 8;
  localparam int VLS_NCH = 2;
  localparam int VLS_NIN = 5;

  typedef enum logic [1:0] {
    VLS_SEQ_OFF = 2'b00,
    VLS_SEQ_RISE = 2'b01,
    VLS_SEQ_STEADY = 2'b10,
    VLS_SEQ_FALL = 2'b11
  } vls_seq_t;

  typedef enum logic [1:0] {
    VLS_MRG_NOMINAL = 2'b00,
    VLS_MRG_HIGH = 2'b01,
    VLS_MRG_LOW = 2'b10
  } vls_margin_t;

  typedef struct packed {
    logic wr;
    logic page;
    logic [7:0] code;
    logic [15:0] data;
  } vls_cmd_t;

  typedef struct packed {
    logic ack;
    logic nack;
    logic [15:0] rdata;
  } vls_resp_t;
endpackage

// [vls_l11_fix.sv]
// registered converter from signed exponent mantissa word to fixed point
// assumes the word is steady or sampled once per use; one cycle latency
`timescale 1ns/10ps
`default_nettype none
module vls_l11_fix
  import vls_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] lin,
  output logic signed [VLS_FIX_W-1:0] fix_r
);
  logic [4:0] shamt;
  logic signed [VLS_FIX_W-1:0] mant_ext;

  // exponent plus sixteen gives a non-negative shift
  always_comb begin
    shamt = lin[VLS_EXP_HI:VLS_EXP_LO] ^ VLS_EXP_BIAS;
    mant_ext = VLS_FIX_W'(signed'(lin[VLS_MAN_W-1:0]));
  end

  // sixteen fractional bits after the shift
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fix_r <= '0;
    end else begin
      fix_r <= mant_ext <<< shamt;
    end
  end

  zero_exp_a: assert property (@(posedge clk) disable iff (!rst_n)
    (lin[VLS_EXP_HI:VLS_EXP_LO] == 5'h00) |=>
      (fix_r == ($past(mant_ext) <<< 16)))
    else $error("converter scaling wrong");
endmodule
`default_nettype wire

// [vls_voltage_limits.sv]
// voltage thresholds, set points and limit checks of a two channel module
// assumes a decoded command port, ADC readings and sequencing state from outside
`timescale 1ns/10ps
`default_nettype none
module vls_voltage_limits
  import vls_pkg::*;
#(
  parameter int RECALC_CYC = VLS_RECALC_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire vls_cmd_t cmd,
  output vls_resp_t resp_r,
  input wire logic [15:0] input_supply_sense,
  input wire logic vin_sample_valid,
  input wire logic [15:0] output_voltage_reading [VLS_NCH],
  input wire logic [VLS_NCH-1:0] vout_sample_valid,
  input wire vls_seq_t seq_state [VLS_NCH],
  input wire vls_margin_t op_margin [VLS_NCH],
  input wire logic [15:0] output_slew_rate,
  input wire logic [VLS_NCH-1:0] overvoltage_pull_down_reaction,
  input wire logic [VLS_NCH-1:0] pwm_top_req,
  input wire logic [VLS_NCH-1:0] pwm_bottom_req,
  input wire logic [VLS_NCH-1:0] warn_clear,
  input wire logic [VLS_NCH-1:0] alert_mask,
  output logic [15:0] vout_setpoint_r [VLS_NCH],
  output logic [VLS_NCH-1:0] top_gate_drive,
  output logic [VLS_NCH-1:0] bottom_gate_drive,
  output logic [VLS_NCH-1:0] fault_pin_assert,
  output logic [VLS_NCH-1:0] out_ov_fault_r,
  output logic [VLS_NCH-1:0] out_uv_fault_r,
  output logic [VLS_NCH-1:0] out_uv_warn_r,
  output logic [VLS_NCH-1:0] out_ov_warn_status_r,
  output logic [VLS_NCH-1:0] output_voltage_status,
  output logic [VLS_NCH-1:0] unlisted_cause_summary_bit,
  output logic alert_active,
  output logic [7:0] common_vendor_status,
  output logic vin_ov_fault_r,
  output logic vin_uv_warn_r,
  output logic power_enable_r
);
  // shared input threshold copies
  logic [15:0] vin_ovf_r, vin_uvw_r, von_r, voff_r;
  // per-channel output command copies
  logic [15:0] nom_r [VLS_NCH];
  logic [15:0] ceil_r [VLS_NCH];
  logic [15:0] mhi_r [VLS_NCH];
  logic [15:0] mlo_r [VLS_NCH];
  logic [15:0] ovf_r [VLS_NCH];
  logic [15:0] ovw_r [VLS_NCH];
  logic [15:0] uvw_r [VLS_NCH];
  logic [15:0] uvf_r [VLS_NCH];
  logic [15:0] tgt_r [VLS_NCH];
  logic [VLS_NCH-1:0] busy;
  logic [15:0] lin_in [VLS_NIN];
  logic signed [VLS_FIX_W-1:0] fix [VLS_NIN];
  logic vin_chk_r;
  logic wr_go, rd_go, known, ro, wr_ok;
  logic [15:0] rd_mux;
  logic [VLS_TICK_W-1:0] tick_cnt_r;
  logic slew_tick;

  // command decode
  always_comb begin
    wr_go = cmd_valid && cmd.wr;
    rd_go = cmd_valid && !cmd.wr;
    known = 1'b1;
    ro = 1'b0;
    unique case (cmd.code)
      VLS_FMT_CODE, VLS_ABS_CODE: ro = 1'b1;
      VLS_NOM_CODE, VLS_CEIL_CODE, VLS_MHI_CODE, VLS_MLO_CODE: ro = 1'b0;
      VLS_VON_CODE, VLS_VOFF_CODE, VLS_OVF_CODE, VLS_OVW_CODE: ro = 1'b0;
      VLS_UVW_CODE, VLS_UVF_CODE, VLS_VIN_OVF_CODE, VLS_VIN_UVW_CODE: ro = 1'b0;
      default: known = 1'b0;
    endcase
    wr_ok = wr_go && known && !ro;
  end

  // read data selection, output copies by page
  always_comb begin
    rd_mux = '0;
    unique case (cmd.code)
      VLS_FMT_CODE: rd_mux = {8'h00, VLS_FMT_VAL};
      VLS_ABS_CODE: rd_mux = VLS_ABS_VAL;
      VLS_NOM_CODE: rd_mux = nom_r[cmd.page];
      VLS_CEIL_CODE: rd_mux = ceil_r[cmd.page];
      VLS_MHI_CODE: rd_mux = mhi_r[cmd.page];
      VLS_MLO_CODE: rd_mux = mlo_r[cmd.page];
      VLS_OVF_CODE: rd_mux = ovf_r[cmd.page];
      VLS_OVW_CODE: rd_mux = ovw_r[cmd.page];
      VLS_UVW_CODE: rd_mux = uvw_r[cmd.page];
      VLS_UVF_CODE: rd_mux = uvf_r[cmd.page];
      VLS_VON_CODE: rd_mux = von_r;
      VLS_VOFF_CODE: rd_mux = voff_r;
      VLS_VIN_OVF_CODE: rd_mux = vin_ovf_r;
      VLS_VIN_UVW_CODE: rd_mux = vin_uvw_r;
      default: rd_mux = '0;
    endcase
  end

  // one-cycle answer: ack on accepted access, nack otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_r <= '0;
    end else begin
      resp_r.ack <= (rd_go && known) || wr_ok;
      resp_r.nack <= cmd_valid && !((rd_go && known) || wr_ok);
      resp_r.rdata <= rd_go ? rd_mux : resp_r.rdata;
    end
  end

  // shared input thresholds, one copy for both pages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vin_ovf_r <= VLS_VIN_OVF_RST;
      vin_uvw_r <= VLS_VIN_UVW_RST;
      von_r <= VLS_VON_RST;
      voff_r <= VLS_VOFF_RST;
    end else if (wr_ok) begin
      if (cmd.code == VLS_VIN_OVF_CODE) vin_ovf_r <= cmd.data;
      if (cmd.code == VLS_VIN_UVW_CODE) vin_uvw_r <= cmd.data;
      if (cmd.code == VLS_VON_CODE) von_r <= cmd.data;
      if (cmd.code == VLS_VOFF_CODE) voff_r <= cmd.data;
    end
  end

  // check one cycle after the sample, once the converter holds it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vin_chk_r <= 1'b0;
    end else begin
      vin_chk_r <= vin_sample_valid;
    end
  end

  // reading, fault, warning, start and stop in fixed point
  always_comb begin
    lin_in[0] = input_supply_sense;
    lin_in[1] = vin_ovf_r;
    lin_in[2] = vin_uvw_r;
    lin_in[3] = von_r;
    lin_in[4] = voff_r;
  end

  for (genvar i = 0; i < VLS_NIN; i++) begin : g_conv
    vls_l11_fix u_conv (
      .clk(clk),
      .rst_n(rst_n),
      .lin(lin_in[i]),
      .fix_r(fix[i])
    );
  end

  // input limit checks on each converted sample, start/stop hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vin_ov_fault_r <= 1'b0;
      vin_uv_warn_r <= 1'b0;
      power_enable_r <= 1'b0;
    end else if (vin_chk_r) begin
      vin_ov_fault_r <= fix[0] > fix[1];
      vin_uv_warn_r <= fix[0] < fix[2];
      if (fix[0] >= fix[3]) begin
        power_enable_r <= 1'b1;
      end else if (fix[0] < fix[4]) begin
        power_enable_r <= 1'b0;
      end
    end
  end

  // divider for the slew step enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (slew_tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign slew_tick = (tick_cnt_r == VLS_TICK_W'(VLS_SLEW_TICK_CYC - 1));

  for (genvar ch = 0; ch < VLS_NCH; ch++) begin : g_ch
    logic pg;
    logic [15:0] sel, clamped, wd_lim, diff;
    logic [VLS_BUSY_W-1:0] busy_cnt_r;

    assign pg = wr_ok && (cmd.page == 1'(ch));
    // ceiling and fault threshold never above the absolute ceiling
    assign wd_lim = (cmd.data > VLS_ABS_VAL) ? VLS_ABS_VAL : cmd.data;

    // per-page output command copies
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        nom_r[ch] <= VLS_NOM_RST;
        ceil_r[ch] <= VLS_CEIL_RST;
        mhi_r[ch] <= VLS_MHI_RST;
        mlo_r[ch] <= VLS_MLO_RST;
        ovf_r[ch] <= VLS_OVF_RST;
        ovw_r[ch] <= VLS_OVW_RST;
        uvw_r[ch] <= VLS_UVW_RST;
        uvf_r[ch] <= VLS_UVF_RST;
      end else if (pg) begin
        if (cmd.code == VLS_NOM_CODE) nom_r[ch] <= cmd.data;
        if (cmd.code == VLS_CEIL_CODE) ceil_r[ch] <= wd_lim;
        if (cmd.code == VLS_MHI_CODE) mhi_r[ch] <= cmd.data;
        if (cmd.code == VLS_MLO_CODE) mlo_r[ch] <= cmd.data;
        if (cmd.code == VLS_OVF_CODE) ovf_r[ch] <= wd_lim;
        if (cmd.code == VLS_OVW_CODE) ovw_r[ch] <= cmd.data;
        if (cmd.code == VLS_UVW_CODE) uvw_r[ch] <= cmd.data;
        if (cmd.code == VLS_UVF_CODE) uvf_r[ch] <= cmd.data;
      end
    end

    // operating point: margin choice then ceiling clamp
    always_comb begin
      unique case (op_margin[ch])
        VLS_MRG_HIGH: sel = mhi_r[ch];
        VLS_MRG_LOW: sel = mlo_r[ch];
        VLS_MRG_NOMINAL: sel = nom_r[ch];
        default: sel = nom_r[ch];
      endcase
      clamped = (sel > ceil_r[ch]) ? ceil_r[ch] : sel;
      diff = (vout_setpoint_r[ch] > tgt_r[ch]) ? vout_setpoint_r[ch] - tgt_r[ch]
                                               : tgt_r[ch] - vout_setpoint_r[ch];
    end

    // new targets are not taken during the on rise or off fall
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        tgt_r[ch] <= VLS_NOM_RST;
      end else if (seq_state[ch] != VLS_SEQ_RISE && seq_state[ch] != VLS_SEQ_FALL) begin
        tgt_r[ch] <= clamped;
      end
    end

    // steady output walks toward the target one slew step per tick
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        vout_setpoint_r[ch] <= VLS_NOM_RST;
      end else if (seq_state[ch] == VLS_SEQ_OFF) begin
        vout_setpoint_r[ch] <= tgt_r[ch];
      end else if (seq_state[ch] == VLS_SEQ_STEADY && slew_tick) begin
        if (diff <= output_slew_rate) begin
          vout_setpoint_r[ch] <= tgt_r[ch];
        end else if (vout_setpoint_r[ch] < tgt_r[ch]) begin
          vout_setpoint_r[ch] <= vout_setpoint_r[ch] + output_slew_rate;
        end else begin
          vout_setpoint_r[ch] <= vout_setpoint_r[ch] - output_slew_rate;
        end
      end
    end

    // recalculation window after a fault threshold write while switching
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        busy_cnt_r <= '0;
      end else if (pg && cmd.code == VLS_OVF_CODE && seq_state[ch] != VLS_SEQ_OFF) begin
        busy_cnt_r <= VLS_BUSY_W'(RECALC_CYC);
      end else if (busy_cnt_r != '0) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
    end
    assign busy[ch] = (busy_cnt_r != '0);

    // output limit checks on ADC readings
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        out_ov_fault_r[ch] <= 1'b0;
        out_uv_warn_r[ch] <= 1'b0;
        out_uv_fault_r[ch] <= 1'b0;
      end else if (vout_sample_valid[ch]) begin
        out_ov_fault_r[ch] <= output_voltage_reading[ch] > ovf_r[ch];
        out_uv_warn_r[ch] <= output_voltage_reading[ch] < uvw_r[ch];
        out_uv_fault_r[ch] <= output_voltage_reading[ch] < uvf_r[ch];
      end
    end

    // sticky overvoltage warning, a new event wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        out_ov_warn_status_r[ch] <= 1'b0;
      end else if (vout_sample_valid[ch] && output_voltage_reading[ch] > ovw_r[ch]) begin
        out_ov_warn_status_r[ch] <= 1'b1;
      end else if (warn_clear[ch]) begin
        out_ov_warn_status_r[ch] <= 1'b0;
      end
    end

    // gate drive override and fault pin under the pull-down reaction
    always_comb begin
      if (out_ov_fault_r[ch] && overvoltage_pull_down_reaction[ch]) begin
        top_gate_drive[ch] = 1'b0;
        bottom_gate_drive[ch] = 1'b1;
      end else begin
        top_gate_drive[ch] = pwm_top_req[ch];
        bottom_gate_drive[ch] = pwm_bottom_req[ch];
      end
      fault_pin_assert[ch] = out_ov_fault_r[ch] && !overvoltage_pull_down_reaction[ch];
    end

    // summary bits follow the warning
    assign output_voltage_status[ch] = out_ov_warn_status_r[ch];
    assign unlisted_cause_summary_bit[ch] = out_ov_warn_status_r[ch];

    ceil_clamp_a: assert property (@(posedge clk) disable iff (!rst_n)
      (seq_state[ch] == VLS_SEQ_STEADY) |=> (tgt_r[ch] <= $past(ceil_r[ch])))
      else $error("target above ceiling");
    defer_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
      (seq_state[ch] == VLS_SEQ_RISE || seq_state[ch] == VLS_SEQ_FALL) |=> $stable(tgt_r[ch]))
      else $error("target moved during sequencing");
    pulldown_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      (out_ov_fault_r[ch] && overvoltage_pull_down_reaction[ch]) |->
        (!top_gate_drive[ch] && bottom_gate_drive[ch] && !fault_pin_assert[ch]))
      else $error("pull-down reaction not applied");
    busy_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (pg && cmd.code == VLS_OVF_CODE && seq_state[ch] != VLS_SEQ_OFF) |=>
        !common_vendor_status[VLS_BUSY_BIT0 + ch] [*2])
      else $error("busy bit not low after threshold write");
    ov_warn_a: assert property (@(posedge clk) disable iff (!rst_n)
      (vout_sample_valid[ch] && output_voltage_reading[ch] > ovw_r[ch]) |=>
        (output_voltage_status[ch] && unlisted_cause_summary_bit[ch] &&
          (alert_active || alert_mask[ch])))
      else $error("warning did not raise status and alert");
    ramp_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      (seq_state[ch] == VLS_SEQ_STEADY && !slew_tick) |=> $stable(vout_setpoint_r[ch]))
      else $error("set point moved between slew ticks");
    margin_cov: cover property (@(posedge clk) disable iff (!rst_n)
      op_margin[ch] == VLS_MRG_HIGH && seq_state[ch] == VLS_SEQ_STEADY ##1
        vout_setpoint_r[ch] != $past(vout_setpoint_r[ch]));
  end

  // alert from unmasked warnings; busy bits active low
  always_comb begin
    alert_active = |(out_ov_warn_status_r & ~alert_mask);
    common_vendor_status = VLS_COMMON_IDLE;
    for (int c = 0; c < VLS_NCH; c++) begin
      common_vendor_status[VLS_BUSY_BIT0 + c] = !busy[c];
    end
  end

  ro_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_go && (cmd.code == VLS_FMT_CODE || cmd.code == VLS_ABS_CODE)) |=> resp_r.nack)
    else $error("read-only write not refused");
  fmt_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_go && cmd.code == VLS_FMT_CODE) |=> (resp_r.ack && resp_r.rdata == 16'h0014))
    else $error("format byte wrong");
  abs_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_go && cmd.code == VLS_ABS_CODE) |=> (resp_r.rdata == 16'h5B34))
    else $error("absolute ceiling wrong");
  vin_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    (vin_chk_r && fix[0] > fix[1]) |=> vin_ov_fault_r)
    else $error("input overvoltage missed");
  start_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (vin_chk_r && fix[0] < fix[4] && fix[0] < fix[3]) |=> !power_enable_r)
    else $error("conversion not stopped");
  vin_cov: cover property (@(posedge clk) disable iff (!rst_n) $rose(power_enable_r));
  nack_cov: cover property (@(posedge clk) disable iff (!rst_n) resp_r.nack);
  busy_cov: cover property (@(posedge clk) disable iff (!rst_n)
    common_vendor_status != VLS_COMMON_IDLE);
endmodule
`default_nettype wire

// [vls_host_model.sv]
// command source standing in for the serial host of the limit block
// assumes one request per call, answer taken one cycle after the request
`timescale 1ns/10ps
`default_nettype none
module vls_host_model
  import vls_pkg::*;
(
  input wire logic clk,
  output logic cmd_valid,
  output vls_cmd_t cmd,
  input wire vls_resp_t resp_r
);
  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // one word per request, ack or nack taken in the answer cycle
  task automatic xfer(input logic wr, input logic pg, input logic [7:0] code,
      input logic [15:0] wd, output logic [1:0] an, output logic [15:0] rd);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{wr: wr, page: pg, code: code, data: wd};
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd.data = ~wd;  // released data does not keep the old value
    an = {resp_r.ack, resp_r.nack};
    rd = resp_r.rdata;
  endtask
endmodule
`default_nettype wire

// [vls_voltage_limits_tb.sv]
// self-checking bench of the voltage limit block, one task per scenario
// assumes the host model drives the command port
`timescale 1ns/10ps
`default_nettype none
module vls_voltage_limits_tb
  import vls_pkg::*;
;
  localparam int RC = 20;
  localparam logic [23:0] TAB [14] = '{24'h200014, 24'h211000, 24'h24599A, 24'h2510CD,
    24'h260F33, 24'h35CAC0, 24'h36CAA0, 24'h40119A, 24'h421133, 24'h430ECD, 24'h440E66,
    24'h55DB60, 24'h58CAA6, 24'hA55B34};
  logic clk, rst_n, cmd_valid, vin_v, alrt, vinf, vinw, pen;
  vls_cmd_t cmd;
  vls_resp_t resp_r;
  logic [15:0] vin_s, rd, slew;
  logic [15:0] rd_v [VLS_NCH];
  logic [15:0] sp [VLS_NCH];
  vls_seq_t seq [VLS_NCH];
  vls_margin_t mrg [VLS_NCH];
  logic [1:0] rd_ok, pdn, ptop, pbot, wclr, amask, tg, bg, fpin, ovf, uvf, uvw, ovw, vst, ucs, an;
  logic [7:0] cvs;
  int num_errors, checks;

  vls_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .resp_r(resp_r));
  vls_voltage_limits #(.RECALC_CYC(RC)) dut (.clk(clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .resp_r(resp_r), .input_supply_sense(vin_s),
    .vin_sample_valid(vin_v), .output_voltage_reading(rd_v), .vout_sample_valid(rd_ok),
    .seq_state(seq), .op_margin(mrg), .output_slew_rate(slew),
    .overvoltage_pull_down_reaction(pdn), .pwm_top_req(ptop), .pwm_bottom_req(pbot),
    .warn_clear(wclr), .alert_mask(amask), .vout_setpoint_r(sp), .top_gate_drive(tg),
    .bottom_gate_drive(bg), .fault_pin_assert(fpin), .out_ov_fault_r(ovf),
    .out_uv_fault_r(uvf), .out_uv_warn_r(uvw), .out_ov_warn_status_r(ovw),
    .output_voltage_status(vst), .unlisted_cause_summary_bit(ucs), .alert_active(alrt),
    .common_vendor_status(cvs), .vin_ov_fault_r(vinf), .vin_uv_warn_r(vinw),
    .power_enable_r(pen));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // let n edges pass, then step just past the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rdc(input logic pg, input logic [7:0] c, input logic [15:0] exp);
    host.xfer(1'b0, pg, c, 16'h0000, an, rd);
    chk("read ack", 16'h0002, {14'h0, an});
    chk("read data", exp, rd);
  endtask
  task automatic samp(input logic [15:0] v);
    @(posedge clk);
    #1;
    rd_v[0] = v;
    rd_ok = 2'b01;
    @(posedge clk);
    #1;
    rd_ok = 2'b00;
  endtask
  task automatic vin(input logic [15:0] v, input logic [2:0] exp);
    vin_s = v;
    vin_v = 1'b1;
    @(posedge clk);
    #1;
    vin_v = 1'b0;
    @(posedge clk);
    #1;
    chk("input flags", {13'h0, exp}, {13'h0, vinf, vinw, pen});
  endtask
  task automatic t_reset();
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 14; i++) begin
        rdc(p[0], TAB[i][23:16], TAB[i][15:0]);
      end
    end
  endtask
  task automatic t_vout();
    samp(16'h119A);
    chk("vout flags", 16'h007A, {8'h0, ovf[0], ovw[0], vst[0], ucs[0], alrt, fpin[0], tg[0], bg[0]});
    amask = 2'b01;
    cyc(1);
    chk("masked alert", 16'h0000, {15'h0, alrt});
    pdn = 2'b01;
    amask = 2'b00;
    samp(16'h1200);
    chk("pull-down flags", 16'h00F9, {8'h0, ovf[0], ovw[0], vst[0], ucs[0], alrt, fpin[0], tg[0], bg[0]});
    pdn = 2'b00;
    wclr = 2'b01;
    samp(16'h0E65);
    wclr = 2'b00;
    chk("cleared flags", 16'h0002, {8'h0, ovf[0], ovw[0], vst[0], ucs[0], alrt, fpin[0], tg[0], bg[0]});
    chk("under flags", 16'h0003, {14'h0, uvf[0], uvw[0]});
    samp(16'h0ECC);
    chk("under warn", 16'h0001, {14'h0, uvf[0], uvw[0]});
  endtask
  task automatic t_busy();
    seq[0] = VLS_SEQ_STEADY;
    host.xfer(1'b1, 1'b0, 8'h40, 16'h1200, an, rd);
    chk("busy", 16'h00DF, {8'h0, cvs});
    cyc(RC - 2);
    chk("still busy", 16'h00DF, {8'h0, cvs});
    cyc(4);
    chk("idle", 16'h00FF, {8'h0, cvs});
  endtask
  task automatic t_sp();
    seq[0] = VLS_SEQ_OFF;
    mrg[0] = VLS_MRG_HIGH;
    cyc(3);
    chk("margin high", 16'h10CD, sp[0]);
    mrg[0] = VLS_MRG_LOW;
    cyc(3);
    chk("margin low", 16'h0F33, sp[0]);
    seq[0] = VLS_SEQ_RISE;
    mrg[0] = VLS_MRG_NOMINAL;
    host.xfer(1'b1, 1'b0, 8'h21, 16'h1100, an, rd);
    cyc(5);
    chk("rise hold", 16'h0F33, sp[0]);
    seq[0] = VLS_SEQ_STEADY;
    cyc(5);
    chk("no jump", 16'h0001, {15'h0, sp[0] != 16'h1100});
    cyc(600);
    chk("ramp end", 16'h1100, sp[0]);
    slew = 16'h0080;
    host.xfer(1'b1, 1'b0, 8'h24, 16'h1000, an, rd);
    cyc(600);
    chk("ceiling", 16'h1000, sp[0]);
  endtask
  task automatic t_access();
    host.xfer(1'b1, 1'b1, 8'h43, 16'h0E00, an, rd);
    rdc(1'b0, 8'h43, 16'h0ECD);
    rdc(1'b1, 8'h43, 16'h0E00);
    host.xfer(1'b1, 1'b1, 8'h58, 16'hCA80, an, rd);
    rdc(1'b0, 8'h58, 16'hCA80);
    host.xfer(1'b1, 1'b0, 8'h20, 16'h0000, an, rd);
    chk("format write", 16'h0001, {14'h0, an});
    rdc(1'b0, 8'h20, 16'h0014);
    host.xfer(1'b1, 1'b0, 8'hA5, 16'h0000, an, rd);
    chk("ceiling write", 16'h0001, {14'h0, an});
    rdc(1'b0, 8'hA5, 16'h5B34);
    host.xfer(1'b0, 1'b0, 8'h00, 16'h0000, an, rd);
    chk("unknown read", 16'h0001, {14'h0, an});
    host.xfer(1'b1, 1'b0, 8'h24, 16'hFFFF, an, rd);
    rdc(1'b0, 8'h24, 16'h5B34);
    host.xfer(1'b1, 1'b1, 8'h40, 16'h6000, an, rd);
    rdc(1'b1, 8'h40, 16'h5B34);
  endtask
  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #60000;
    num_errors++;
    final_report();
  end
  // reset, then scenarios in turn
  initial begin
    rst_n = 1'b0;
    {vin_v, rd_ok, pdn, pbot, wclr, amask} = '0;
    ptop = 2'b11;
    vin_s = 16'h0000;
    slew = 16'h0100;
    rd_v = '{16'h1000, 16'h1000};
    seq = '{VLS_SEQ_OFF, VLS_SEQ_OFF};
    mrg = '{VLS_MRG_NOMINAL, VLS_MRG_NOMINAL};
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_vout();
    t_busy();
    t_sp();
    vin(16'hCAC0, 3'b001);
    vin(16'hCAA0, 3'b011);
    vin(16'hCA00, 3'b010);
    vin(16'hDB61, 3'b101);
    vin(16'hDB60, 3'b001);
    t_access();
    final_report();
  end
endmodule
`default_nettype wire
